// File: design/iar_pkg.sv
// iar_pkg: constants and types of the alarm record builder.
// assumes: shared by the builder top and its two helper modules.
package iar_pkg;
    // header field values
    localparam logic [15:0] BT_DIAG      = 16'h0002;
    localparam logic [15:0] BT_PROC      = 16'h0001;
    localparam logic [15:0] BLK_VERSION  = 16'h0100;
    localparam logic [15:0] AT_DIAG      = 16'h0001;
    localparam logic [15:0] AT_PROC      = 16'h0002;
    localparam logic [31:0] API_DEFAULT  = 32'h0000_0000;
    // maintenance item block
    localparam logic [15:0] USI_MAINT    = 16'h8100;
    localparam logic [15:0] MI_TYPE      = 16'h0F00;
    localparam logic [15:0] MI_LENGTH    = 16'h0008;
    localparam logic [15:0] MI_VERSION   = 16'h0001;
    localparam logic [15:0] MI_RESERVED  = 16'h0000;
    localparam logic [31:0] MS_REQUIRED  = 32'h0000_0001;
    localparam logic [31:0] MS_DEMANDED  = 32'h0000_0002;
    // extended channel diagnosis block
    localparam logic [15:0] USI_EXT_DIAG = 16'h8002;
    localparam logic [15:0] CHAN_SUBMOD  = 16'h8000;
    // channel properties codes
    localparam logic [1:0]  SPEC_CLEARED = 2'b00;
    localparam logic [1:0]  SPEC_APPEAR  = 2'b01;
    localparam logic [1:0]  SPEC_GONE    = 2'b10;
    localparam logic [1:0]  QUAL_NONE    = 2'b00;
    localparam logic [1:0]  QUAL_REQ     = 2'b01;  // bit 9
    localparam logic [1:0]  QUAL_DEM     = 2'b10;  // bit 10
    // alarm specifier sequence width and bit positions
    localparam int SPC_SEQ_W   = 11;
    localparam int SPC_CH_AV   = 11;
    localparam int SPC_MANUF   = 12;
    localparam int SPC_CH_ANY  = 13;
    localparam int SPC_AR_DIAG = 15;
    // slot and subslot addresses
    localparam logic [15:0] SLOT_HEAD    = 16'h0000;
    localparam logic [15:0] SLOT_BRK     = 16'h0001;
    localparam logic [15:0] SUB_HEAD     = 16'h0001;
    localparam logic [15:0] SUB_IFACE    = 16'h8000;
    localparam logic [15:0] SUB_PORT1    = 16'h8001;
    localparam logic [15:0] SUB_PORT2    = 16'h8002;
    localparam logic [15:0] SUB_BRK      = 16'h0001;
    // record geometry in bytes, total record width in bits
    localparam int HDR_BYTES = 26;
    localparam int BLK_BYTES = 14;
    localparam int TAG_BYTES = 4;
    localparam int REC_W     = 8 * (HDR_BYTES + 2 * BLK_BYTES);
    // byte offsets of header fields
    localparam int OFS_LEN  = 2;
    localparam int OFS_VER  = 4;
    localparam int OFS_AT   = 6;
    localparam int OFS_API  = 8;
    localparam int OFS_SLOT = 12;
    localparam int OFS_SUB  = 14;
    localparam int OFS_SPEC = 24;

    typedef enum logic [1:0] {
        KIND_DIAG  = 2'b00,
        KIND_PROC  = 2'b01,
        KIND_MAINT = 2'b10
    } iar_kind_t;

    typedef enum logic [2:0] {
        LOC_HEAD  = 3'b000,
        LOC_IFACE = 3'b001,
        LOC_PORT1 = 3'b010,
        LOC_PORT2 = 3'b011,
        LOC_BRK   = 3'b100
    } iar_loc_t;

    // slot in the upper half, subslot in the lower half
    function automatic logic [31:0] loc_addr(input logic [2:0] loc);
        case (loc)
            LOC_IFACE: loc_addr = {SLOT_HEAD, SUB_IFACE};
            LOC_PORT1: loc_addr = {SLOT_HEAD, SUB_PORT1};
            LOC_PORT2: loc_addr = {SLOT_HEAD, SUB_PORT2};
            LOC_BRK:   loc_addr = {SLOT_BRK, SUB_BRK};
            default:   loc_addr = {SLOT_HEAD, SUB_HEAD};
        endcase
    endfunction
endpackage

// File: design/iar_seq_cnt.sv
// iar_seq_cnt: wrapping alarm sequence number.
// assumes: adv is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
module iar_seq_cnt #(
    parameter int W = iar_pkg::SPC_SEQ_W
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         adv,
    output logic      [W-1:0] seq
);
    logic [W-1:0] seq_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            seq_r <= '0;
        end else if (adv) begin
            seq_r <= seq_r + W'(1);  // wraps to zero past the top
        end
    end

    assign seq = seq_r;
endmodule // iar_seq_cnt
`default_nettype wire

// File: design/iar_chan_props.sv
// iar_chan_props: packs the channel properties word.
// assumes: inputs are steady while the record is latched.
`timescale 1ns/1ps
`default_nettype none
module iar_chan_props #(
    parameter logic [15:0] CHAN_NUM = iar_pkg::CHAN_SUBMOD
) (
    input  wire logic [2:0]  width_code,
    input  wire logic        group,
    input  wire logic [1:0]  qual,
    input  wire logic [1:0]  spec,
    input  wire logic [2:0]  dir,
    output logic      [15:0] props
);
    logic [7:0] type_code;

    always_comb begin
        if (CHAN_NUM == iar_pkg::CHAN_SUBMOD) begin
            type_code = 8'h00;
        end else begin
            type_code = {5'h00, width_code};
        end
    end

    assign props = {dir, spec, qual, group, type_code};
endmodule // iar_chan_props
`default_nettype wire

// File: design/iar_builder.sv
// iar_builder: builds alarm records and streams them out byte-wise.
// assumes: requests come from logic on CLK; the sink obeys valid/ready.
`timescale 1ns/1ps
`default_nettype none
module iar_builder #(
    parameter logic [15:0] CHAN_NUM = iar_pkg::CHAN_SUBMOD
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    // alarm request
    input  wire logic        REQ_VALID,
    output logic             REQ_READY,
    input  wire logic [1:0]  REQ_KIND,
    input  wire logic [2:0]  REQ_LOC,
    input  wire logic [31:0] REQ_MODULE_ID,
    input  wire logic [31:0] REQ_SUBMOD_ID,
    input  wire logic        REQ_MANUF_INFO,
    input  wire logic        REQ_CH_ANY,
    input  wire logic        REQ_AR_DIAG,
    input  wire logic        REQ_APPEAR,
    input  wire logic        REQ_ALL_CLEAR,
    input  wire logic        REQ_DEMANDED,
    input  wire logic        REQ_GROUP,
    input  wire logic [2:0]  REQ_WIDTH,
    input  wire logic [2:0]  REQ_DIR,
    input  wire logic [15:0] REQ_ERR_TYPE,
    input  wire logic [15:0] REQ_EXT_ERR,
    input  wire logic [31:0] REQ_ADD_VALUE,
    // record byte stream
    output logic             OUT_VALID,
    input  wire logic        OUT_READY,
    output logic [7:0]       OUT_DATA,
    output logic             OUT_FIRST,
    output logic             OUT_LAST,
    // status
    output logic [10:0]      SEQ_NUM
);
    localparam int RW = iar_pkg::REC_W;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } iar_state_t;

    iar_state_t            state_r;
    logic       [RW-1:0]   rec_r;
    logic       [RW-1:0]   rec_nxt;
    logic       [5:0]      cnt_r;
    logic       [5:0]      last_r;
    logic       [1:0]      kind_r;
    logic                  dem_r;
    logic                  req_fire;
    logic                  out_fire;
    logic       [10:0]     seq;
    logic       [15:0]     props;
    logic       [1:0]      qual;
    logic       [1:0]      spec;
    logic       [15:0]     rec_len;
    logic       [15:0]     alarm_spec;
    logic       [207:0]    hdr;
    logic       [111:0]    blk_chan;
    logic       [111:0]    blk_maint;
    logic                  is_maint;

    // 16-bit field at a byte offset of a latched record
    function automatic logic [15:0] hw16(input logic [RW-1:0] r,
                                         input int ofs);
        hw16 = r[RW-1-8*ofs -: 16];
    endfunction

    // header length for a record with n blocks
    function automatic logic [15:0] len_for(input int n);
        len_for = 16'(iar_pkg::HDR_BYTES + n * iar_pkg::BLK_BYTES
                      - iar_pkg::TAG_BYTES);
    endfunction

    // request and stream handshakes
    assign req_fire  = REQ_VALID && REQ_READY;
    assign out_fire  = OUT_VALID && OUT_READY;
    assign REQ_READY = (state_r == ST_IDLE);
    assign OUT_VALID = (state_r == ST_SEND);
    assign OUT_FIRST = OUT_VALID && (cnt_r == 6'h00);
    assign OUT_LAST  = OUT_VALID && (cnt_r == last_r);
    assign is_maint  = (REQ_KIND == iar_pkg::KIND_MAINT);

    iar_seq_cnt #(.W (iar_pkg::SPC_SEQ_W)) u_seq (
        .clk (CLK),
        .rst (RST),
        .adv (req_fire),
        .seq (seq)
    );
    assign SEQ_NUM = seq;

    always_comb begin
        if (!is_maint) begin
            qual = iar_pkg::QUAL_NONE;
        end else if (REQ_DEMANDED) begin
            qual = iar_pkg::QUAL_DEM;
        end else begin
            qual = iar_pkg::QUAL_REQ;
        end
    end

    always_comb begin
        if (REQ_ALL_CLEAR && !is_maint) begin
            spec = iar_pkg::SPEC_CLEARED;
        end else if (REQ_APPEAR) begin
            spec = iar_pkg::SPEC_APPEAR;
        end else begin
            spec = iar_pkg::SPEC_GONE;
        end
    end

    // group flag drives the accumulative bit
    iar_chan_props #(.CHAN_NUM (CHAN_NUM)) u_props (
        .width_code (REQ_WIDTH),
        .group      (REQ_GROUP),
        .qual       (qual),
        .spec       (spec),
        .dir        (REQ_DIR),
        .props      (props)
    );

    // sequence plus flags, reserved bit zero
    always_comb begin
        alarm_spec = {5'h00, seq};
        alarm_spec[iar_pkg::SPC_CH_AV]   = 1'b1;  // channel info always
        alarm_spec[iar_pkg::SPC_MANUF]   = REQ_MANUF_INFO;
        alarm_spec[iar_pkg::SPC_CH_ANY]  = REQ_CH_ANY;
        alarm_spec[iar_pkg::SPC_AR_DIAG] = REQ_AR_DIAG;
    end

    // length excludes type and length words
    assign rec_len = is_maint ? len_for(2) : len_for(1);

    // kind picks block and alarm type
    assign hdr = {
        (REQ_KIND == iar_pkg::KIND_PROC) ? iar_pkg::BT_PROC
                                         : iar_pkg::BT_DIAG,
        rec_len,
        iar_pkg::BLK_VERSION,
        (REQ_KIND == iar_pkg::KIND_PROC) ? iar_pkg::AT_PROC
                                         : iar_pkg::AT_DIAG,
        iar_pkg::API_DEFAULT,
        iar_pkg::loc_addr(REQ_LOC),
        REQ_MODULE_ID,
        REQ_SUBMOD_ID,
        alarm_spec
    };

    assign blk_chan = {
        iar_pkg::USI_EXT_DIAG,
        CHAN_NUM,
        props,
        REQ_ERR_TYPE,
        REQ_EXT_ERR,
        REQ_ADD_VALUE
    };

    assign blk_maint = {
        iar_pkg::USI_MAINT,
        iar_pkg::MI_TYPE,
        iar_pkg::MI_LENGTH,
        iar_pkg::MI_VERSION,
        iar_pkg::MI_RESERVED,
        REQ_DEMANDED ? iar_pkg::MS_DEMANDED : iar_pkg::MS_REQUIRED
    };

    // one or two blocks after the header
    always_comb begin
        if (is_maint) begin
            rec_nxt = {hdr, blk_maint, blk_chan};
        end else begin
            rec_nxt = {hdr, blk_chan, 112'h0};
        end
    end

    // record shift register, high byte leaves first
    always_ff @(posedge CLK) begin
        if (RST) begin
            rec_r <= '0;
        end else if (req_fire) begin
            rec_r <= rec_nxt;
        end else if (out_fire) begin
            rec_r <= {rec_r[RW-9:0], 8'h00};
        end
    end
    assign OUT_DATA = rec_r[RW-1 -: 8];

    // per-record attributes
    always_ff @(posedge CLK) begin
        if (RST) begin
            kind_r <= iar_pkg::KIND_DIAG;
            dem_r  <= 1'b0;
            last_r <= 6'h00;
        end else if (req_fire) begin
            kind_r <= REQ_KIND;
            dem_r  <= REQ_DEMANDED;
            last_r <= 6'(rec_len + 16'(iar_pkg::TAG_BYTES) - 16'h0001);
        end
    end

    // byte counter and state
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= ST_IDLE;
            cnt_r   <= 6'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    cnt_r <= 6'h00;
                    if (req_fire) begin
                        state_r <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (out_fire) begin
                        if (cnt_r == last_r) begin
                            state_r <= ST_IDLE;
                            cnt_r   <= 6'h00;
                        end else begin
                            cnt_r <= cnt_r + 6'h01;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    cnt_r   <= 6'h00;
                end
            endcase
        end
    end

    // checks on the record as it stands before its first byte
    logic send_start;
    assign send_start = OUT_VALID && (cnt_r == 6'h00);

    // first byte is block type high
    property p_first_byte;
        @(posedge CLK) disable iff (RST)
        OUT_FIRST |-> (OUT_DATA == 8'h00);
    endproperty
    a_first_byte: assert property (p_first_byte)
        else $error("first byte is not block type high byte");
    // second byte is block type low
    property p_bt_low;
        @(posedge CLK) disable iff (RST)
        (OUT_FIRST && OUT_READY) ##1 OUT_VALID |->
            (OUT_DATA == ((kind_r == iar_pkg::KIND_PROC) ? 8'h01 : 8'h02));
    endproperty
    a_bt_low: assert property (p_bt_low)
        else $error("block type low byte wrong for kind");
    // length set by kind and agrees with stream end
    property p_len;
        @(posedge CLK) disable iff (RST)
        send_start |->
            (hw16(rec_r, iar_pkg::OFS_LEN) + 16'(iar_pkg::TAG_BYTES) ==
                16'(iar_pkg::HDR_BYTES + iar_pkg::BLK_BYTES *
                    ((kind_r == iar_pkg::KIND_MAINT) ? 2 : 1))) &&
            (16'(last_r) + 16'h0001 == hw16(rec_r, iar_pkg::OFS_LEN)
                                        + 16'(iar_pkg::TAG_BYTES));
    endproperty
    a_len: assert property (p_len)
        else $error("length field does not match record size");
    property p_ver_api;
        @(posedge CLK) disable iff (RST)
        send_start |->
            (hw16(rec_r, iar_pkg::OFS_VER) == iar_pkg::BLK_VERSION) &&
            (hw16(rec_r, iar_pkg::OFS_API) == 16'h0000) &&
            (hw16(rec_r, iar_pkg::OFS_API + 2) == 16'h0000);
    endproperty
    a_ver_api: assert property (p_ver_api)
        else $error("version or application id wrong");
    property p_brk_addr;
        @(posedge CLK) disable iff (RST)
        (req_fire && REQ_LOC == iar_pkg::LOC_BRK) |=>
            (hw16(rec_r, iar_pkg::OFS_SLOT) == iar_pkg::SLOT_BRK) &&
            (hw16(rec_r, iar_pkg::OFS_SUB) == iar_pkg::SUB_BRK);
    endproperty
    a_brk_addr: assert property (p_brk_addr)
        else $error("breaker slot or subslot wrong");
    property p_spec_seq;
        @(posedge CLK) disable iff (RST)
        req_fire |=>
            (hw16(rec_r, iar_pkg::OFS_SPEC) ==
                ({5'h00, $past(seq)} | 16'h0800 |
                 {$past(REQ_AR_DIAG), 1'b0, $past(REQ_CH_ANY),
                  $past(REQ_MANUF_INFO), 12'h000}));
    endproperty
    a_spec_seq: assert property (p_spec_seq)
        else $error("alarm specifier wrong");
    property p_seq_step;
        @(posedge CLK) disable iff (RST)
        req_fire |=> (seq == $past(seq) + 11'h001);
    endproperty
    a_seq_step: assert property (p_seq_step)
        else $error("sequence number did not advance by one");
    property p_maint_status;
        @(posedge CLK) disable iff (RST)
        send_start && (kind_r == iar_pkg::KIND_MAINT) |->
            (rec_r[RW-1-8*(iar_pkg::HDR_BYTES+13) -: 8] ==
                (dem_r ? 8'h02 : 8'h01));
    endproperty
    a_maint_status: assert property (p_maint_status)
        else $error("maintenance status wrong");
    property p_chan_usi;
        @(posedge CLK) disable iff (RST)
        send_start && (kind_r != iar_pkg::KIND_MAINT) |->
            (hw16(rec_r, iar_pkg::HDR_BYTES) == iar_pkg::USI_EXT_DIAG) &&
            (hw16(rec_r, iar_pkg::HDR_BYTES + 2) == CHAN_NUM);
    endproperty
    a_chan_usi: assert property (p_chan_usi)
        else $error("channel block header wrong");
    property p_hold;
        @(posedge CLK) disable iff (RST)
        OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA);
    endproperty
    a_hold: assert property (p_hold)
        else $error("output byte changed while stalled");
    // record ends and frees the request side
    property p_end;
        @(posedge CLK) disable iff (RST)
        OUT_LAST && OUT_READY |=> REQ_READY && !OUT_VALID;
    endproperty
    a_end: assert property (p_end)
        else $error("record did not end after last byte");
endmodule // iar_builder
`default_nettype wire

// File: tb/iar_ctrl_sink.sv
// iar_ctrl_sink: controller-side sink for the alarm record byte stream.
// assumes: valid/ready on clk; bench reads mem and cnt after a record.
`timescale 1ns/1ps
`default_nettype none
module iar_ctrl_sink (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic       stall,
    input  wire logic       valid,
    output logic            ready,
    input  wire logic [7:0] data,
    input  wire logic       first,
    input  wire logic       last
);
    logic [9:0] mem [0:127];
    int         cnt;
    logic [2:0] ph = 3'h0;
    // store each taken byte with its framing flags
    always @(posedge clk) begin
        if (rst || clr) begin
            cnt <= 0;
        end else if (valid && ready) begin
            mem[cnt] <= {first, last, data};
            cnt      <= cnt + 1;
        end
        ph <= ph + 3'h1;
    end
    logic       rdy_r = 1'b0;
    // ready moves just after the edge; uneven gaps when stalling
    always @(posedge clk) begin
        rdy_r <= #1 !stall || (ph != 3'h1 && ph != 3'h4 && ph != 3'h5);
    end
    assign ready = rdy_r;
endmodule // iar_ctrl_sink
`default_nettype wire

// File: tb/io_alarm_record_builder_tb.sv
// io_alarm_record_builder_tb: self-checking bench of the record builder.
// assumes: sink model in iar_ctrl_sink; default CHAN_NUM of 0x8000.
`timescale 1ns/1ps
`default_nettype none
module io_alarm_record_builder_tb;
    logic        clk, rst, req_valid, req_ready, stall, clr;
    logic [1:0]  kind;
    logic [2:0]  loc, width, dir;
    logic [31:0] mod_id, sub_id, add_val;
    logic        manuf, ch_any, ar_diag, appear, all_clr, dem, grp;
    logic [15:0] err, ext;
    logic        out_valid, out_ready, out_first, out_last;
    logic [7:0]  out_data;
    logic [10:0] seq_num, cur_seq;
    logic [9:0]  exp_q[$];
    int          mismatches, comparisons;

    iar_builder u_dut (.CLK(clk), .RST(rst), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ_KIND(kind), .REQ_LOC(loc),
        .REQ_MODULE_ID(mod_id), .REQ_SUBMOD_ID(sub_id),
        .REQ_MANUF_INFO(manuf), .REQ_CH_ANY(ch_any), .REQ_AR_DIAG(ar_diag),
        .REQ_APPEAR(appear), .REQ_ALL_CLEAR(all_clr), .REQ_DEMANDED(dem),
        .REQ_GROUP(grp), .REQ_WIDTH(width), .REQ_DIR(dir),
        .REQ_ERR_TYPE(err), .REQ_EXT_ERR(ext), .REQ_ADD_VALUE(add_val),
        .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_DATA(out_data),
        .OUT_FIRST(out_first), .OUT_LAST(out_last), .SEQ_NUM(seq_num));
    iar_ctrl_sink u_sink (.clk(clk), .rst(rst), .clr(clr), .stall(stall),
        .valid(out_valid), .ready(out_ready), .data(out_data),
        .first(out_first), .last(out_last));

    // free-running 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic p16(input logic [15:0] v);
        exp_q.push_back({2'b00, v[15:8]});
        exp_q.push_back({2'b00, v[7:0]});
    endtask

    task automatic p32(input logic [31:0] v);
        p16(v[31:16]);
        p16(v[15:0]);
    endtask

    // request fields from a test number, kind, place and flag set
    task automatic setf(input logic [7:0] n, input logic [1:0] k,
                        input logic [2:0] l, input logic [6:0] f);
        {appear, all_clr, dem, grp, manuf, ch_any, ar_diag} = f;
        kind    = k;
        loc     = l;
        mod_id  = 32'hA5C3_1F00 + {24'h0, n};
        sub_id  = ~mod_id;
        err     = 16'h0100 + {8'h00, n};
        ext     = 16'hBEEF - {8'h00, n};
        add_val = {n, 8'h3C, ~n, 8'h81};
        width   = n[2:0];
        dir     = n[2:0] + 3'h1;
    endtask

    // expected record for the current fields, then the request itself
    task automatic alarm();
        int          s;
        logic [1:0]  cs, q;
        logic [31:0] sa;
        s = exp_q.size();
        p16(kind == 2'b01 ? 16'h0001 : 16'h0002);
        p16(kind == 2'b10 ? 16'h0032 : 16'h0024);
        p16(16'h0100);
        p16(kind == 2'b01 ? 16'h0002 : 16'h0001);
        p32(32'h0000_0000);
        case (loc)
            3'h1: sa = 32'h0000_8000;
            3'h2: sa = 32'h0000_8001;
            3'h3: sa = 32'h0000_8002;
            3'h4: sa = 32'h0001_0001;
            default: sa = 32'h0000_0001;
        endcase
        p32(sa);
        p32(mod_id);
        p32(sub_id);
        p16({ar_diag, 1'b0, ch_any, manuf, 1'b1, cur_seq});
        if (kind == 2'b10) begin
            p32(32'h8100_0F00);
            p32(32'h0008_0001);
            p16(16'h0000);
            p32(dem ? 32'h0000_0002 : 32'h0000_0001);
        end
        cs = (all_clr && kind != 2'b10) ? 2'b00 : (appear ? 2'b01 : 2'b10);
        q  = kind == 2'b10 ? (dem ? 2'b10 : 2'b01) : 2'b00;
        p32(32'h8002_8000);
        p16({dir, cs, q, grp, 8'h00});
        p16(err);
        p16(ext);
        p32(add_val);
        exp_q[s][9]              = 1'b1;
        exp_q[exp_q.size()-1][8] = 1'b1;
        send();
    endtask

    // offer the request and hold it until the accept edge
    task automatic send();
        int i;
        @(posedge clk);
        #1 req_valid = 1'b1;
        for (i = 0; i < 400 && req_ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 400) begin
            mismatches++;
            complete_run();
        end
        @(posedge clk);
        #1 req_valid = 1'b0;
        cur_seq = cur_seq + 11'h001;
        chk("ready while busy", 32'h0, {31'h0, req_ready});
        chk("first byte flag", 32'h1, {31'h0, out_first & out_valid});
        chk("sequence number", {21'h0, cur_seq}, {21'h0, seq_num});
    endtask

    // wait for all expected bytes and compare them
    task automatic drain(input string name);
        int i;
        for (i = 0; i < 3000 && u_sink.cnt < exp_q.size(); i++)
            @(posedge clk);
        if (i == 3000) begin
            mismatches++;
            complete_run();
        end
        repeat (3) @(posedge clk);
        #1;
        chk("byte count", exp_q.size(), u_sink.cnt);
        foreach (exp_q[k])
            chk("record byte", exp_q[k], u_sink.mem[k]);
        chk("idle valid", 32'h0, {31'h0, out_valid});
        chk("idle ready", 32'h1, {31'h0, req_ready});
        exp_q.delete();
        clr = 1'b1;
        @(posedge clk);
        #1 clr = 1'b0;
        $display("test %s done", name);
    endtask

    // reset, then the alarm sequences
    initial begin
        {req_valid, stall, clr, cur_seq} = '0;
        setf(8'h00, 2'b00, 3'h0, 7'h00);
        mismatches  = 0;
        comparisons = 0;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        chk("reset ready", 32'h1, {31'h0, req_ready});
        chk("reset valid", 32'h0, {31'h0, out_valid});
        chk("reset sequence", 32'h0, {21'h0, seq_num});
        setf(8'h01, 2'b00, 3'h0, 7'b1000101);
        alarm();
        drain("diagnostic head");
        stall = 1'b1;
        setf(8'h02, 2'b01, 3'h4, 7'b0101010);
        alarm();
        drain("process breaker");
        setf(8'h03, 2'b10, 3'h2, 7'b1001011);
        alarm();
        drain("maintenance required");
        stall = 1'b0;
        setf(8'h04, 2'b10, 3'h3, 7'b0110100);
        alarm();
        drain("maintenance demanded");
        setf(8'h05, 2'b00, 3'h1, 7'b0100111);
        alarm();
        setf(8'h06, 2'b11, 3'h7, 7'b1010000);
        alarm();
        drain("back to back");
        // reset in mid-run brings the sequence back to zero
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        cur_seq = '0;
        chk("mid reset valid", 32'h0, {31'h0, out_valid});
        chk("mid reset sequence", 32'h0, {21'h0, seq_num});
        setf(8'h07, 2'b01, 3'h1, 7'b0000000);
        alarm();
        drain("after reset");
        complete_run();
    end
endmodule // io_alarm_record_builder_tb
`default_nettype wire
